/* hdl/isf_top.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - set check-byte error flag, bit 11, when received check byte mismatches
// - a mismatching check byte is answered with not-acknowledge automatically
// - all status flags forced to zero while peripheral enable is low
// - without SMBus, check-byte, timeout and alert flags and clears read zero
// - set timeout flag, bit 12, on bus timeout or clock-low timeout
// - set alert flag, bit 13, on alert fall with host address and alert enabled
// - busy flag, bit 15, set by start, cleared by stop or disable
// - direction bit 16 updated on address match, 1 means read
// - matched address captured into bits 23:17 on address match
// - clear bit 3 clears address match flag and control start bit
// - clear bit 4 clears not-acknowledge flag
// - clear bit 5 clears stop seen flag
// - clear bits 8, 9, 10 clear bus error, arbitration lost, overrun
// - clear bits 11, 12, 13 clear check error, timeout, alert flags
// - clear register resets to zero; reserved bits ignored on write
// - arbitration lost flag, bit 9, set on loss, cleared by clear or disable
module isf_top #(
    parameter bit SMBUS_SUPPORT = 1'b1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alert_pin,
    input wire logic start_det,
    input wire logic stop_det,
    input wire logic addr_match,
    input wire logic match_read,
    input wire logic [6:0] match_code,
    input wire logic not_ack_det,
    input wire logic bus_error_det,
    input wire logic arb_lost_det,
    input wire logic overrun_det,
    input wire logic check_byte_valid,
    input wire logic [7:0] check_byte_rx,
    input wire logic [7:0] check_value,
    input wire logic timeout_det,
    input wire logic clock_low_timeout_det,
    input wire logic start_set,
    output logic nack_request,
    output logic peripheral_enable,
    output logic start_bit,
    output logic irq
);
    typedef struct packed {
        logic [31:0] status;
        logic [3:0] control;
        logic [5:0] events;
        logic [5:0] mask;
        logic nack_req;
        logic [31:0] rdata;
    } isf_state_t;

    isf_state_t r;
    isf_state_t next_r;
    isf_evt_if ev ();

    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [31:0] clear_bits;
    logic check_mismatch;
    logic host_addr_en;
    logic alert_en;
    logic going_off;

    // =====================================
    // line event detection
    isf_edge u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .alert_pin(alert_pin),
        .start_det(start_det),
        .stop_det(stop_det),
        .ev(ev)
    );

    // =====================================
    // bus decode; zero-wait slave so every access phase completes at once
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign mapped = (paddr == isf_pkg::CLEAR_OFFSET) || (paddr == isf_pkg::STATUS_OFFSET)
        || (paddr == isf_pkg::CONFIG_OFFSET) || (paddr == isf_pkg::EVENT_OFFSET)
        || (paddr == isf_pkg::MASK_OFFSET) || (paddr == isf_pkg::CHECK_OFFSET);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;

    // only documented clear positions act; smbus ones vanish without smbus
    assign clear_bits = (wr_en && paddr == isf_pkg::CLEAR_OFFSET)
        ? (pwdata & isf_pkg::CLEAR_MASK & (SMBUS_SUPPORT ? 32'hFFFFFFFF : ~isf_pkg::SMBUS_MASK))
        : 32'h00000000;

    assign check_mismatch = check_byte_valid && (check_byte_rx != check_value);
    assign host_addr_en = r.control[isf_pkg::HOST_ADDR_BIT];
    assign alert_en = r.control[isf_pkg::ALERT_EN_BIT];
    // a disabling write empties the flags at once, not one cycle after enable drops
    assign going_off = wr_en && (paddr == isf_pkg::CONFIG_OFFSET)
        && !pwdata[isf_pkg::ENABLE_BIT];

    // =====================================
    // next state
    always_comb begin
        logic en;
        logic [31:0] st;
        logic [5:0] ev_now;
        logic [31:0] rd;
        en = r.control[isf_pkg::ENABLE_BIT];
        st = r.status;
        ev_now = 6'h00;
        rd = 32'h00000000;
        next_r = r;

        // software clears first so a simultaneous hardware set wins
        st = st & ~clear_bits;
        if (not_ack_det) begin
            st[isf_pkg::NOT_ACK_BIT] = 1'b1;
        end
        if (stop_det) begin
            st[isf_pkg::STOP_BIT] = 1'b1;
        end
        if (bus_error_det) begin
            st[isf_pkg::BUS_ERROR_BIT] = 1'b1;
        end
        if (overrun_det) begin
            st[isf_pkg::OVERRUN_BIT] = 1'b1;
        end
        if (arb_lost_det) begin
            st[isf_pkg::ARB_LOST_BIT] = 1'b1;
            ev_now[isf_pkg::EV_ARB] = 1'b1;
        end
        if (SMBUS_SUPPORT && check_mismatch) begin
            st[isf_pkg::CHECK_ERROR_BIT] = 1'b1;
            ev_now[isf_pkg::EV_CHECK] = 1'b1;
        end
        if (SMBUS_SUPPORT && (timeout_det || clock_low_timeout_det)) begin
            st[isf_pkg::TIMEOUT_BIT] = 1'b1;
            ev_now[isf_pkg::EV_TIMEOUT] = 1'b1;
        end
        if (SMBUS_SUPPORT && ev.alert_fall && host_addr_en && alert_en) begin
            st[isf_pkg::ALERT_BIT] = 1'b1;
            ev_now[isf_pkg::EV_ALERT] = 1'b1;
        end
        // stop clears busy; a start in the same cycle opens a new frame
        if (ev.stop_seen) begin
            st[isf_pkg::BUSY_BIT] = 1'b0;
        end
        if (ev.start_seen) begin
            st[isf_pkg::BUSY_BIT] = 1'b1;
            ev_now[isf_pkg::EV_BUSY] = 1'b1;
        end
        if (addr_match) begin
            st[isf_pkg::ADDR_MATCH_BIT] = 1'b1;
            st[isf_pkg::DIRECTION_BIT] = match_read;
            st[isf_pkg::CODE_MSB:isf_pkg::CODE_LSB] = match_code;
            ev_now[isf_pkg::EV_MATCH] = 1'b1;
        end
        if (!SMBUS_SUPPORT) begin
            st = st & ~isf_pkg::SMBUS_MASK;
        end
        if (!en || going_off) begin
            st = isf_pkg::RESET_VALUE;
            ev_now = 6'h00;
        end
        next_r.status = st;

        // nack pulse answers the bad check byte
        next_r.nack_req = SMBUS_SUPPORT && en && check_mismatch;

        // control register; hardware start set loses to the clear bit
        if (wr_en && paddr == isf_pkg::CONFIG_OFFSET) begin
            next_r.control = pwdata[3:0];
        end else if (start_set) begin
            next_r.control[isf_pkg::START_BIT] = 1'b1;
        end
        if (clear_bits[isf_pkg::ADDR_MATCH_BIT]) begin
            next_r.control[isf_pkg::START_BIT] = 1'b0;
        end

        if (wr_en && paddr == isf_pkg::MASK_OFFSET) begin
            next_r.mask = pwdata[5:0];
        end

        // sticky events; a read clears only what it returned, so an event landing
        // between setup and access is kept for the next read
        if (rd_en && paddr == isf_pkg::EVENT_OFFSET) begin
            next_r.events = (r.events & ~r.rdata[5:0]) | ev_now;
        end else begin
            next_r.events = r.events | ev_now;
        end

        // read data from flops; clear register always reads zero
        unique case (paddr)
            isf_pkg::STATUS_OFFSET: rd = r.status;
            isf_pkg::CONFIG_OFFSET: rd = {28'h0000000, r.control};
            isf_pkg::EVENT_OFFSET: rd = {26'h0, r.events};
            isf_pkg::MASK_OFFSET: rd = {26'h0, r.mask};
            isf_pkg::CHECK_OFFSET: rd = {24'h000000, check_value};
            default: rd = 32'h00000000;
        endcase
        if (psel && !penable && !pwrite) begin
            next_r.rdata = rd;
        end
    end

    // =====================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.rdata;
    assign nack_request = r.nack_req;
    assign peripheral_enable = r.control[isf_pkg::ENABLE_BIT];
    assign start_bit = r.control[isf_pkg::START_BIT];
    assign irq = |(r.events & r.mask);
endmodule
`default_nettype wire

/* hdl/isf_pkg.sv */
`default_nettype none
package isf_pkg;
    // register byte offsets; printed clear offset is a multiple of four
    localparam logic [7:0] CLEAR_OFFSET = 8'h1C;
    localparam logic [7:0] STATUS_OFFSET = 8'h18;
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] EVENT_OFFSET = 8'h04;
    localparam logic [7:0] MASK_OFFSET = 8'h08;
    localparam logic [7:0] CHECK_OFFSET = 8'h20;
    // status and clear field positions
    localparam int ADDR_MATCH_BIT = 3;
    localparam int NOT_ACK_BIT = 4;
    localparam int STOP_BIT = 5;
    localparam int BUS_ERROR_BIT = 8;
    localparam int ARB_LOST_BIT = 9;
    localparam int OVERRUN_BIT = 10;
    localparam int CHECK_ERROR_BIT = 11;
    localparam int TIMEOUT_BIT = 12;
    localparam int ALERT_BIT = 13;
    localparam int BUSY_BIT = 15;
    localparam int DIRECTION_BIT = 16;
    localparam int CODE_LSB = 17;
    localparam int CODE_MSB = 23;
    // clear bits that do anything; all others are reserved
    localparam logic [31:0] CLEAR_MASK = 32'h00003F38;
    localparam logic [31:0] SMBUS_MASK = 32'h00003800;
    // config register fields
    localparam int ENABLE_BIT = 0;
    localparam int HOST_ADDR_BIT = 1;
    localparam int ALERT_EN_BIT = 2;
    localparam int START_BIT = 3;
    localparam logic [31:0] RESET_VALUE = 32'h00000000;
    // event bits of the sticky event register
    localparam int EV_CHECK = 0;
    localparam int EV_TIMEOUT = 1;
    localparam int EV_ALERT = 2;
    localparam int EV_ARB = 3;
    localparam int EV_BUSY = 4;
    localparam int EV_MATCH = 5;
    localparam int EVENT_COUNT = 6;
endpackage
`default_nettype wire

/* hdl/isf_evt_if.sv */
`timescale 1ns/100ps
`default_nettype none
// line events handed from the edge detector to the flag logic
interface isf_evt_if;
    logic alert_fall;
    logic start_seen;
    logic stop_seen;
    modport source (output alert_fall, output start_seen, output stop_seen);
    modport sink (input alert_fall, input start_seen, input stop_seen);
endinterface
`default_nettype wire

/* hdl/isf_edge.sv */
`timescale 1ns/100ps
`default_nettype none
module isf_edge (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic alert_pin,
    input wire logic start_det,
    input wire logic stop_det,
    isf_evt_if.source ev
);
    typedef struct packed {
        logic alert_last;
    } isf_edge_t;
    isf_edge_t r;
    isf_edge_t next_r;

    // =====================================
    // alert pin edge; idle high so reset to one avoids a false fall
    always_comb begin
        next_r = r;
        next_r.alert_last = alert_pin;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{alert_last: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    assign ev.alert_fall = r.alert_last & ~alert_pin;
    assign ev.start_seen = start_det;
    assign ev.stop_seen = stop_det;
endmodule
`default_nettype wire

/* tb/isf_bus_dev.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// bus side: one-cycle line events on command, alert idles high
module isf_bus_dev (
    input wire logic pclk,
    input wire logic [3:0] op,
    input wire logic go,
    output logic [10:0] ev,
    output logic alert_pin
);
    // line starts idle so no false fall after power-up
    initial begin
        ev = '0;
        alert_pin = 1'b1;
    end
    // events last one cycle, as the line detectors would give them
    always @(posedge pclk) begin
        ev <= go ? (11'(1) << op) : 11'h000;
        alert_pin <= !(go && op == 4'hB);
    end
endmodule
`default_nettype wire

/* tb/isf_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// port checks of the flag block
module isf_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic check_byte_valid,
    input wire logic [7:0] check_byte_rx,
    input wire logic [7:0] check_value,
    input wire logic nack_request,
    input wire logic peripheral_enable,
    input wire logic start_bit
);
    logic acc;
    logic bad;
    // access phase with zero wait states
    assign acc = psel && penable;
    assign bad = check_byte_valid && check_byte_rx != check_value;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    nack_pulse_a: assert property (
        bad && peripheral_enable |=> nack_request) else $error("no nack");
    nack_cause_a: assert property (
        nack_request |-> $past(bad)) else $error("nack without mismatch");
    nack_off_a: assert property (
        bad && !peripheral_enable |=> !nack_request) else $error("nack while off");
    nack_once_a: assert property (
        nack_request |=> !nack_request || $past(bad)) else $error("nack too long");
    start_clr_a: assert property (
        acc && pwrite && paddr == 8'h1C && pwdata[3] |=> !start_bit)
        else $error("start kept");
    start_keep_a: assert property (
        acc && pwrite && paddr == 8'h1C && !pwdata[3] && start_bit |=> start_bit)
        else $error("start lost");
    clr_read_a: assert property (
        acc && !pwrite && paddr == 8'h1C |-> prdata == 32'h0) else $error("clear reads");
    off_status_a: assert property (
        acc && !pwrite && paddr == 8'h18 && !peripheral_enable |-> prdata == 32'h0)
        else $error("status while off");
endmodule
bind isf_top isf_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .check_byte_valid(check_byte_valid), .check_byte_rx(check_byte_rx),
    .check_value(check_value), .nack_request(nack_request),
    .peripheral_enable(peripheral_enable), .start_bit(start_bit));
`default_nettype wire

/* tb/isf_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ====
// flag block bench
module isf_top_tb;
    logic pclk, presetn, psel, penable, pwrite, match_read, go, pready, pslverr;
    logic nack_request, peripheral_enable, start_bit, irq, alert_pin, rerr;
    logic [7:0] paddr, rx;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] op;
    logic [6:0] code;
    logic [10:0] ev;
    int fail_count, n_compared, b;
    int bits[12] = '{15, 5, 3, 4, 8, 9, 10, 11, 12, 12, 0, 13};
    isf_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .alert_pin(alert_pin), .start_det(ev[0]), .stop_det(ev[1]),
        .addr_match(ev[2]), .match_read(match_read), .match_code(code),
        .not_ack_det(ev[3]), .bus_error_det(ev[4]), .arb_lost_det(ev[5]),
        .overrun_det(ev[6]), .check_byte_valid(ev[7]), .check_byte_rx(rx),
        .check_value(8'h5A), .timeout_det(ev[8]), .clock_low_timeout_det(ev[9]),
        .start_set(ev[10]), .nack_request(nack_request),
        .peripheral_enable(peripheral_enable), .start_bit(start_bit), .irq(irq));
    isf_bus_dev BUS (.pclk(pclk), .op(op), .go(go), .ev(ev), .alert_pin(alert_pin));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic close_out;
        $display("compared %0d bad %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (pready !== 1'b1) begin
            chk("pready", 1, 0);
            close_out;
        end else begin
            rd = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic fire(input logic [3:0] o);
        op <= o; go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // every event sets its bit; its clear bit drops it; busy only by stop
    task automatic t_flags;
        xfer(0, 8'h1C, 0);
        chk("clr reset", 0, rd);
        xfer(1, 8'h00, 32'h7);
        for (int i = 0; i < 12; i++) begin
            if (i == 10) continue;
            b = bits[i];
            fire(4'(i));
            xfer(0, 8'h18, 0);
            chk("flag set", 1 << b, rd & (1 << b));
            if (i == 2) chk("dir code", 8'hAB, rd[23:16]);
            xfer(1, 8'h1C, 1 << b);
            xfer(0, 8'h18, 0);
            chk("flag clr", i == 0 ? 32'h8000 : 0, rd & (32'h8000 | (1 << b)));
        end
        // second match with a write direction and another code
        match_read <= 1'b0;
        code <= 7'h2A;
        fire(4'h2);
        xfer(0, 8'h18, 0);
        chk("dir write", 32'h00540008, rd & 32'h00FF0008);
        $display("done flags");
    endtask
    // gated events, reserved and zero clear bits, write-only read
    task automatic t_gate;
        xfer(1, 8'h00, 32'h1);
        rx <= 8'h5A;
        fire(4'hB);
        fire(4'h7);
        fire(4'h5);
        xfer(1, 8'h1C, 32'hFFFFC0C7);
        xfer(0, 8'h18, 0);
        chk("gated", 32'h200, rd & 32'h2A00);
        xfer(0, 8'h1C, 0);
        chk("clr read", 0, rd);
        $display("done gate");
    endtask
    task automatic t_start;
        fire(4'hA);
        chk("start", 1, start_bit);
        xfer(1, 8'h1C, 32'h10);
        chk("start kept", 1, start_bit);
        xfer(1, 8'h1C, 32'h8);
        chk("start clr", 0, start_bit);
        $display("done start");
    endtask
    // earlier scenarios left events behind; drain them so irq must come from this one
    task automatic t_irq;
        xfer(0, 8'h04, 0);
        xfer(1, 8'h08, 32'h8);
        chk("irq idle", 0, irq);
        fire(4'h5);
        chk("irq on", 1, irq);
        xfer(0, 8'h04, 0);
        chk("event", 8, rd & 8);
        chk("irq off", 0, irq);
        $display("done irq");
    endtask
    // disable wipes every flag and mutes check-byte answers
    task automatic t_off;
        rx <= 8'hA5;
        fire(4'h0);
        fire(4'h5);
        xfer(1, 8'h00, 0);
        fire(4'h7);
        xfer(0, 8'h18, 0);
        chk("off", 0, rd);
        chk("enable off", 0, peripheral_enable);
        xfer(0, 8'hFC, 0);
        chk("slverr", 1, rerr);
        $display("done off");
    endtask
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 0; match_read = 1'b1; go = 1'b0; op = 4'h0; rx = 8'hA5;
        code = 7'h55;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_flags;
        t_gate;
        t_start;
        t_irq;
        t_off;
        close_out;
    end
endmodule
`default_nettype wire
